//--- logic/posref_pkg.sv
// Constants, register map and state types for the position reference generator.
package posref_pkg;

    localparam logic [7:0] ADDR_RAMP_ACCELERATION = 8'h1d;
    localparam logic [7:0] ADDR_CMD_TYPE = 8'h34;
    localparam logic [7:0] ADDR_BIAS_HI = 8'h48;
    localparam logic [7:0] ADDR_BIAS_LO = 8'h49;
    localparam logic [7:0] ADDR_TGT_HI = 8'h4a;
    localparam logic [7:0] ADDR_TGT_LO = 8'h4b;
    localparam logic [7:0] ADDR_SLOPE = 8'h4c;
    localparam logic [7:0] ADDR_STEP_CODE = 8'h50;
    localparam logic [7:0] ADDR_MEAS_HI = 8'h5f;
    localparam logic [7:0] ADDR_MEAS_LO = 8'h60;
    localparam logic [7:0] ADDR_UPDATE = 8'h76;

    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [4:0] RST_RAMP_ACCELERATION = 5'h01;
    localparam logic [15:0] RST_SLOPE = 16'h0064;
    localparam logic [15:0] RST_STEP_CODE = 16'h0004;
    localparam logic [15:0] UPDATE_KEY = 16'h0000;
    localparam logic [3:0] STRAP_CODE_BASE = 4'h4;

    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 100000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

    // An acceleration step of 1 equals one eighth of a position LSB per tick per tick.
    localparam int FRAC_BITS = 3;
    localparam int POS_W = 32 + FRAC_BITS;
    localparam int SPD_W = 16 + FRAC_BITS;

    typedef enum logic [3:0] {
        GEN_IDLE = 4'b0001,
        GEN_ACCEL = 4'b0010,
        GEN_CRUISE = 4'b0100,
        GEN_BRAKE = 4'b1000
    } gen_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [11:0] tick_cnt;
        logic tick;
        logic step_prev;
        logic [4:0] ramp_acceleration;
        logic cmd_incremental;
        logic [31:0] bias;
        logic [31:0] cmd;
        logic [15:0] slope;
        logic [15:0] step_code;
        logic [31:0] target;
        logic [POS_W-1:0] pos;
        logic [SPD_W-1:0] spd;
        logic dir_neg;
        gen_mode_t mode;
        logic [15:0] rdata;
        logic rvalid;
    } gen_state_t;

endpackage

//--- logic/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] pins_sync
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage to contain metastability.
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r <= '0;
            pins_sync <= '0;
        end else begin
            meta_r <= pins;
            pins_sync <= meta_r;
        end
    end
endmodule // pin_sync

//--- logic/position_reference_generator.sv
// Position-mode reference generator with register and step/direction command paths.
`timescale 1ns/10ps

module position_reference_generator
    import posref_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [31:0] measured_position,
    input wire logic step_input,
    input wire logic dir_input,
    input wire logic pulse_mode_select,
    input wire logic resolution_from_straps,
    input wire logic resolution_strap_0,
    input wire logic resolution_strap_1,
    input wire logic resolution_strap_2,
    output logic [31:0] position_reference,
    output logic [15:0] reference_speed,
    output logic reference_dir_neg,
    output logic tick_pulse,
    output logic in_motion
);
    gen_state_t st_r;
    gen_state_t st_nxt;
    logic [5:0] pins_s;
    logic step_s;
    logic dir_s;
    logic pulse_mode_s;
    logic strap_sel_s;
    logic [2:0] straps_s;
    logic [3:0] eff_code;
    logic [31:0] step_incr;
    logic step_rise;
    logic upd_write;
    logic [POS_W-1:0] err;
    logic [POS_W-1:0] mag_err;
    logic err_neg;
    logic [SPD_W-1:0] accel;
    logic [SPD_W-1:0] limit;
    logic [47:0] stop_need;
    logic [47:0] stop_room;
    logic short_room;

    pin_sync #(.W(6)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .pins({step_input, dir_input, pulse_mode_select, resolution_from_straps,
               resolution_strap_2, resolution_strap_1}),
        .pins_sync(pins_s)
    );

    logic strap0_meta_r;
    logic strap0_s_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            strap0_meta_r <= 1'b0;
            strap0_s_r <= 1'b0;
        end else begin
            strap0_meta_r <= resolution_strap_0;
            strap0_s_r <= strap0_meta_r;
        end
    end

    assign step_s = pins_s[5];
    assign dir_s = pins_s[4];
    assign pulse_mode_s = pins_s[3];
    assign strap_sel_s = pins_s[2];
    assign straps_s = {pins_s[1:0], strap0_s_r};

    // Straps are read continuously so a board can rework them without a reset.
    assign eff_code = strap_sel_s ? ({1'b0, straps_s} + STRAP_CODE_BASE)
                                  : st_r.step_code[3:0];
    assign step_incr = 32'h0000_0001 << eff_code;
    assign step_rise = pulse_mode_s && step_s && !st_r.step_prev;
    assign upd_write = reg_req.wr && reg_req.addr == ADDR_UPDATE
                       && reg_req.wdata == UPDATE_KEY;

    assign err = {st_r.target, {FRAC_BITS{1'b0}}} - st_r.pos;
    assign err_neg = err[POS_W-1];
    assign mag_err = err_neg ? (~err + 1'b1) : err;
    // A zero acceleration field would stall the ramp forever, so it acts as 1.
    assign accel = (st_r.ramp_acceleration == 5'h00) ? SPD_W'(1) : SPD_W'(st_r.ramp_acceleration);
    assign limit = {st_r.slope, {FRAC_BITS{1'b0}}};
    // Distance to stop is v(v+a)/2a; cross-multiplied to avoid a divider.
    assign stop_need = 48'(st_r.spd) * 48'({1'b0, st_r.spd} + {1'b0, accel});
    assign stop_room = 48'(accel) * 48'({mag_err, 1'b0});
    assign short_room = stop_need >= stop_room;

    always_comb begin
        logic [SPD_W-1:0] v;
        logic moving_away;
        v = st_r.spd;
        moving_away = (st_r.spd != '0) && (st_r.dir_neg != err_neg);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.rvalid = 1'b0;
        st_nxt.step_prev = step_s;
        if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 12'h001;
        end
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_RAMP_ACCELERATION: st_nxt.ramp_acceleration = reg_req.wdata[4:0];
                ADDR_CMD_TYPE: st_nxt.cmd_incremental = reg_req.wdata[0];
                ADDR_BIAS_HI: st_nxt.bias[31:16] = reg_req.wdata;
                ADDR_BIAS_LO: st_nxt.bias[15:0] = reg_req.wdata;
                ADDR_TGT_HI: st_nxt.cmd[31:16] = reg_req.wdata;
                ADDR_TGT_LO: st_nxt.cmd[15:0] = reg_req.wdata;
                ADDR_SLOPE: st_nxt.slope = reg_req.wdata;
                ADDR_STEP_CODE: st_nxt.step_code = reg_req.wdata;
                default: st_nxt.cmd = st_r.cmd;
            endcase
        end
        if (reg_req.rd) begin
            st_nxt.rvalid = 1'b1;
            case (reg_req.addr)
                ADDR_RAMP_ACCELERATION: st_nxt.rdata = {11'h000, st_r.ramp_acceleration};
                ADDR_CMD_TYPE: st_nxt.rdata = {15'h0000, st_r.cmd_incremental};
                ADDR_BIAS_HI: st_nxt.rdata = st_r.bias[31:16];
                ADDR_BIAS_LO: st_nxt.rdata = st_r.bias[15:0];
                ADDR_TGT_HI: st_nxt.rdata = st_r.cmd[31:16];
                ADDR_TGT_LO: st_nxt.rdata = st_r.cmd[15:0];
                ADDR_SLOPE: st_nxt.rdata = st_r.slope;
                ADDR_STEP_CODE: st_nxt.rdata = st_r.step_code;
                ADDR_MEAS_HI: st_nxt.rdata = measured_position[31:16];
                ADDR_MEAS_LO: st_nxt.rdata = measured_position[15:0];
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        if (st_r.tick) begin
            case (st_r.mode)
                GEN_IDLE: begin
                    st_nxt.spd = '0;
                end
                GEN_ACCEL, GEN_CRUISE, GEN_BRAKE: begin
                    if (mag_err <= POS_W'(accel) && st_r.spd <= accel) begin
                        // Final approach lands exactly on target at rest.
                        st_nxt.pos = {st_r.target, {FRAC_BITS{1'b0}}};
                        v = '0;
                        st_nxt.mode = GEN_IDLE;
                    end else begin
                        if (moving_away || short_room) begin
                            v = (st_r.spd > accel) ? (st_r.spd - accel) : '0;
                            st_nxt.mode = GEN_BRAKE;
                        end else if ({1'b0, st_r.spd} + {1'b0, accel} <= {1'b0, limit}) begin
                            v = st_r.spd + accel;
                            st_nxt.mode = GEN_ACCEL;
                        end else begin
                            v = limit;
                            st_nxt.mode = GEN_CRUISE;
                        end
                        if (st_r.spd == '0) begin
                            st_nxt.dir_neg = err_neg;
                        end
                        if ((st_r.spd == '0) ? err_neg : st_r.dir_neg) begin
                            st_nxt.pos = st_r.pos - POS_W'(v);
                        end else begin
                            st_nxt.pos = st_r.pos + POS_W'(v);
                        end
                    end
                    st_nxt.spd = v;
                end
                default: st_nxt.mode = GEN_IDLE;
            endcase
        end
        if (upd_write) begin
            if (st_r.cmd_incremental) begin
                st_nxt.target = st_r.target + st_r.cmd;
            end else begin
                st_nxt.target = st_r.cmd + st_r.bias;
            end
            if (st_r.mode == GEN_IDLE) begin
                st_nxt.mode = GEN_ACCEL;
            end
        end else if (step_rise) begin
            if (dir_s) begin
                st_nxt.target = st_r.target + step_incr;
            end else begin
                st_nxt.target = st_r.target - step_incr;
            end
            if (st_r.mode == GEN_IDLE) begin
                st_nxt.mode = GEN_ACCEL;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '{tick_cnt: 12'h000, tick: 1'b0, step_prev: 1'b0, ramp_acceleration: RST_RAMP_ACCELERATION,
                      cmd_incremental: 1'b0, bias: {RST_ZERO, RST_ZERO},
                      cmd: {RST_ZERO, RST_ZERO}, slope: RST_SLOPE,
                      step_code: RST_STEP_CODE, target: 32'h0000_0000,
                      pos: '0, spd: '0, dir_neg: 1'b0, mode: GEN_IDLE,
                      rdata: 16'h0000, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign position_reference = st_r.pos[POS_W-1:FRAC_BITS];
    assign reference_speed = st_r.spd[SPD_W-1:FRAC_BITS];
    assign reference_dir_neg = st_r.dir_neg;
    assign tick_pulse = st_r.tick;
    assign in_motion = st_r.mode != GEN_IDLE;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_TICK_PERIOD: assert property (tick_pulse |=> !tick_pulse [*8] ##0
        (st_r.tick_cnt == 12'h008)) else $error("Tick spacing wrong.");
    AST_TICK_DUE: assert property ((st_r.tick_cnt == TICK_LAST) |=> tick_pulse)
        else $error("Tick missed at end of period.");
    AST_SPEED_CLAMP: assert property (st_r.spd <= limit || $changed(st_r.slope)
        || $past(st_r.slope) != st_r.slope || !$past(st_r.tick))
        else $error("Speed above limit after a tick.");
    AST_ACCEL_BOUND: assert property ($past(st_r.tick) && st_r.spd > $past(st_r.spd)
        |-> st_r.spd - $past(st_r.spd) <= $past(accel)) else $error("Ramp too steep.");
    AST_REST_WHEN_IDLE: assert property (!in_motion && $past(st_r.tick)
        |-> st_r.spd == '0) else $error("Idle with nonzero speed.");
    AST_ADOPT_ON_UPDATE: assert property ($changed(st_r.target)
        |-> $past(upd_write) || $past(step_rise)) else $error("Target moved without cause.");
    AST_ABS_CMD: assert property (upd_write && !st_r.cmd_incremental
        |=> st_r.target == $past(st_r.cmd) + $past(st_r.bias)) else $error("Absolute target bad.");
    AST_STEP_DIR: assert property (step_rise && !upd_write
        |=> st_r.target == ($past(dir_s) ? $past(st_r.target) + $past(step_incr)
                                        : $past(st_r.target) - $past(step_incr)))
        else $error("Step target bad.");
    AST_STRAP_CODE: assert property (strap_sel_s
        |-> eff_code == {1'b0, straps_s} + 4'h4) else $error("Strap code bad.");
    AST_RAMP_ACCELERATION_RSVD: assert property (reg_req.rd && reg_req.addr == ADDR_RAMP_ACCELERATION
        |=> reg_rvalid && reg_rdata[15:5] == 11'h000) else $error("Reserved bits set.");
    AST_RESET_VALUES: assert property ($past(rst) |-> st_r.step_code == RST_STEP_CODE
        && st_r.slope == RST_SLOPE && st_r.ramp_acceleration == RST_RAMP_ACCELERATION) else $error("Reset value bad.");

    COV_REACH_LIMIT: cover property (st_r.mode == GEN_CRUISE ##1 st_r.mode == GEN_BRAKE);
    COV_REACCEL: cover property (st_r.mode == GEN_BRAKE ##1 st_r.mode == GEN_ACCEL);
    COV_ARRIVE: cover property (st_r.mode == GEN_BRAKE ##1 st_r.mode == GEN_IDLE);
    COV_STEP: cover property (step_rise);
endmodule // position_reference_generator

//--- testbench/step_source.sv
// Step and direction pin model of the host side.
`timescale 1ns/10ps
module step_source (
    input wire logic mclk,
    output logic step_pin,
    output logic dir_pin
);
    initial begin
        step_pin = 1'b0;
        dir_pin = 1'b0;
    end
    // Each level is held for hold cycles, at least 3, so the synchroniser never drops an edge.
    task automatic send(input int n, input logic up, input int hold);
        repeat (hold) @(negedge mclk);
        dir_pin = up;
        for (int i = 0; i < n; i++) begin
            repeat (hold) @(negedge mclk);
            step_pin = 1'b1;
            repeat (hold) @(negedge mclk);
            step_pin = 1'b0;
        end
    endtask
endmodule // step_source

//--- testbench/tb_position_reference_generator.sv
// Self-checking bench for the position reference generator.
`timescale 1ns/10ps
module tb_position_reference_generator;
    import posref_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_t reg_req = '0;
    logic [31:0] meas = 32'h1234_5678;
    logic pulse_mode = 1'b0;
    logic from_straps = 1'b0;
    logic [2:0] straps = 3'h0;
    logic [15:0] reg_rdata, reference_speed;
    logic [15:0] top_spd = 16'h0000;
    logic [31:0] position_reference;
    logic reg_rvalid, reference_dir_neg, tick_pulse, in_motion, step_pin, dir_pin;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int last_tick = 0;
    int tick_gap = 0;

    position_reference_generator position_reference_generator_i (
        .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .measured_position(meas), .step_input(step_pin),
        .dir_input(dir_pin), .pulse_mode_select(pulse_mode),
        .resolution_from_straps(from_straps), .resolution_strap_0(straps[0]),
        .resolution_strap_1(straps[1]), .resolution_strap_2(straps[2]),
        .position_reference(position_reference), .reference_speed(reference_speed),
        .reference_dir_neg(reference_dir_neg), .tick_pulse(tick_pulse),
        .in_motion(in_motion)
    );
    step_source step_source_i (.mclk(mclk), .step_pin(step_pin), .dir_pin(dir_pin));

    always #20 mclk = ~mclk;

    // Tick spacing and peak speed are watched all the time, not only when a test looks.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tick_pulse === 1'b1) begin
            last_tick <= cyc;
            tick_gap <= cyc - last_tick;
        end
        if (reference_speed > top_spd) begin
            top_spd <= reference_speed;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        reg_req = '0;
    endtask

    // The answer comes one cycle after the read; a missing answer is a mismatch.
    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge mclk);
        reg_req = '0;
        while (reg_rvalid !== 1'b1 && n < 3) begin
            @(negedge mclk);
            n++;
        end
        check({31'h0, reg_rvalid}, 32'h1, "read answer");
        check({16'h0000, reg_rdata}, {16'h0000, exp}, $sformatf("read %h", a));
    endtask

    task automatic settle(input logic [31:0] exp);
        int n;
        n = 0;
        repeat (4) @(negedge mclk);
        while (in_motion !== 1'b0 && n < 60000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 60000) begin
            bad_count++;
            $display("Error at %0t: move never finished", $time);
            test_done();
        end
        check(position_reference, exp, "final position");
        check({16'h0000, reference_speed}, 32'h0, "final speed");
    endtask

    task automatic t_reset;
        rd_check(ADDR_RAMP_ACCELERATION, 16'h0001);
        rd_check(ADDR_CMD_TYPE, 16'h0000);
        rd_check(ADDR_BIAS_HI, 16'h0000);
        rd_check(ADDR_BIAS_LO, 16'h0000);
        rd_check(ADDR_TGT_HI, 16'h0000);
        rd_check(ADDR_TGT_LO, 16'h0000);
        rd_check(ADDR_SLOPE, 16'h0064);
        rd_check(ADDR_STEP_CODE, 16'h0004);
        rd_check(ADDR_MEAS_HI, 16'h1234);
        rd_check(ADDR_MEAS_LO, 16'h5678);
        rd_check(8'h00, 16'h0000);
        reg_wr(ADDR_RAMP_ACCELERATION, 16'hffff);
        rd_check(ADDR_RAMP_ACCELERATION, 16'h001f);
        $display("reset test done");
    endtask

    task automatic t_abs;
        reg_wr(ADDR_SLOPE, 16'h0004);
        reg_wr(ADDR_TGT_HI, 16'hffff);
        reg_wr(ADDR_TGT_LO, 16'hfff0);
        reg_wr(ADDR_UPDATE, 16'h0001);
        repeat (20) @(negedge mclk);
        check({31'h0, in_motion}, 32'h0, "early motion");
        check(position_reference, 32'h0, "early position");
        top_spd = 16'h0000;
        reg_wr(ADDR_UPDATE, UPDATE_KEY);
        settle(32'hfffffff0);
        check({16'h0000, top_spd}, 32'h4, "peak speed");
        check({31'h0, reference_dir_neg}, 32'h1, "direction after falling move");
        check(tick_gap, TICK_CYCLES, "tick spacing");
        $display("absolute move test done");
    endtask

    task automatic t_bias_incr;
        reg_wr(ADDR_SLOPE, 16'h0010);
        reg_wr(ADDR_BIAS_LO, 16'h0010);
        reg_wr(ADDR_TGT_HI, 16'h0000);
        reg_wr(ADDR_TGT_LO, 16'h0020);
        reg_wr(ADDR_UPDATE, UPDATE_KEY);
        settle(32'h00000030);
        check({31'h0, reference_dir_neg}, 32'h0, "direction after rising move");
        reg_wr(ADDR_CMD_TYPE, 16'h0001);
        reg_wr(ADDR_TGT_LO, 16'h0010);
        reg_wr(ADDR_UPDATE, UPDATE_KEY);
        settle(32'h00000040);
        $display("offset and incremental test done");
    endtask

    // Straps 001 give code 5, an increment of 32; register code 3 gives 8.
    task automatic t_pulse;
        pulse_mode = 1'b1;
        from_straps = 1'b1;
        straps = 3'b001;
        step_source_i.send(2, 1'b1, 3);
        settle(32'h00000080);
        step_source_i.send(1, 1'b0, 6);
        settle(32'h00000060);
        from_straps = 1'b0;
        reg_wr(ADDR_STEP_CODE, 16'h0003);
        step_source_i.send(1, 1'b1, 3);
        settle(32'h00000068);
        pulse_mode = 1'b0;
        step_source_i.send(1, 1'b1, 3);
        repeat (10) @(negedge mclk);
        check(position_reference, 32'h00000068, "step outside pulse mode");
        $display("pulse test done");
    endtask

    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_abs();
        t_bias_incr();
        t_pulse();
        test_done();
    end
endmodule // tb_position_reference_generator
